// ==== irp_map.svh ====
/*
  Register map, field positions and timing figures for the
  indexed register port and controller status word.
  Assumes inclusion by bare name from the design file.
*/
`ifndef IRP_MAP_SVH
`define IRP_MAP_SVH

`define IRP_OFS_DATA 5'h10
`define IRP_OFS_PTR_WORD 5'h12
`define IRP_OFS_PTR_DWORD 5'h14
`define IRP_OFS_RESET 5'h14
`define IRP_OFS_CFG_WORD 5'h16
`define IRP_OFS_CFG_DWORD 5'h1C

`define IRP_IDX_STATUS 8'h00
`define IRP_IDX_MASK 8'h03

`define IRP_BIT_ERR 15
`define IRP_BIT_BABBLE 14
`define IRP_BIT_COLL 13
`define IRP_BIT_MISS 12
`define IRP_BIT_BUS_TIMEOUT 11
`define IRP_BIT_INIT_DONE 8
`define IRP_BIT_SUMMARY 7
`define IRP_BIT_GATE 6
`define IRP_BIT_STOP 2

`define IRP_BABBLE_BYTES 11'd1519
`define IRP_SQE_BIT_TIMES 20
`define IRP_BIT_TIME_NS 100
`define IRP_CLK_NS 50
`define IRP_BUS_TIMEOUT_NS 51200

`endif

// ==== irp_pkg.sv ====
/*
  Types shared by the indexed register port design.
  Uses no constants from irp_map.svh; state encodings are local.
*/
package irp_pkg;
  typedef enum logic [2:0] {
    IRP_SQE_IDLE = 3'b001,
    IRP_SQE_WAIT = 3'b010,
    IRP_SQE_DONE = 3'b100
  } irp_sqe_type;
endpackage

// ==== irp_regs.sv ====
/*
  Indexed register port and controller status word: pointer register, status
  word with write-one-to-clear error flags, mask register and interrupt pin.
  Assumes a synchronous host port (address, read and write strobes, 32-bit data)
  and event pulses from the MAC, buffer manager and bus interface on core_clk.
*/
// Contract
// - Pointer low eight bits select status or configuration register for data access.
// - Pointer sits at 12h in word mode, 14h in double-word mode.
// - Offset 10h reaches the status-space register selected by pointer.
// - Offset 16h word, 1Ch double-word reaches the indexed configuration register.
// - Pointer bits 15-8 read zero; upper bits read zero here.
// - Pointer cleared by hardware or software reset, kept across stop.
// - Bit 15 is the OR of the four error flags, read-only.
// - Babble flag sets when a transmit frame reaches 1519 bytes.
// - Babble interrupts when gate is one and its mask is zero.
// - Error and done flags clear on write one; zero leaves them.
// - Error and done flags cleared by either reset or stop.
// - Collision flag sets when no collision within 20 bit times after transmit.
// - Twisted-pair mode: transmit attempt during link fail sets collision flag.
// - Collision flag never interrupts but does set the error summary.
// - Missed-frame flag sets on frame dropped for lack of descriptor; interrupts unmasked.
// - Bus-grant timeout flag sets when hold waits unacknowledged for programmed timeout.
// - Bus timeout sets error summary always, interrupts only when gated and unmasked.
// - Init-done flag sets after initialization block read; interrupts when unmasked.
// - Bit 7 is summary of unmasked sources; pin active only when gated.
// - Bit 6 gates the pin; written directly, cleared by reset or stop.
// - Stop happens only when one is written to a stop bit now zero.
// - Reading offset 14h performs a software reset.
`timescale 1ns/1ps
`include "irp_map.svh"

module irp_regs #(
  parameter int BUS_TIMEOUT_CYCLES = `IRP_BUS_TIMEOUT_NS / `IRP_CLK_NS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic dword_mode,
  input wire logic [4:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic [7:0] cfg_index,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic tx_active,
  input wire logic tx_byte,
  input wire logic tx_attempt,
  input wire logic tx_end,
  input wire logic collision_in,
  input wire logic twisted_pair_mode,
  input wire logic link_fail,
  input wire logic frame_missed,
  input wire logic hold_req,
  input wire logic bus_grant_acknowledge,
  input wire logic init_read_done,
  input wire logic [5:0] other_pending,
  output logic stop_state,
  output logic soft_reset_pulse,
  output logic irq
);
  localparam int SQE_CYCLES = `IRP_SQE_BIT_TIMES * `IRP_BIT_TIME_NS / `IRP_CLK_NS;
  localparam int SQE_LATE = SQE_CYCLES + 1;

  logic [7:0] register_index_pointer_q;
  logic babble_flag_q, collision_heartbeat_flag_q, missed_frame_flag_q;
  logic bus_grant_timeout_flag_q, init_done_flag_q, interrupt_gate_q, stop_q;
  logic [15:0] interrupt_mask_register_q;
  logic [10:0] tx_count_q;
  logic [15:0] bus_wait_count_q;
  logic [5:0] sqe_count_q;
  irp_pkg::irp_sqe_type sqe_q;
  logic babble_set, coll_set, sqe_fail;
  logic ptr_hit, data_hit, cfg_hit, sw_reset, stop_pulse, status_wr;
  logic error_summary, interrupt_summary;
  logic [15:0] status_word;

  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    w1c = set | (flag & ~clr);
  endfunction

  assign ptr_hit = host_addr == (dword_mode ? `IRP_OFS_PTR_DWORD : `IRP_OFS_PTR_WORD);
  assign data_hit = host_addr == `IRP_OFS_DATA;
  assign cfg_hit = host_addr == (dword_mode ? `IRP_OFS_CFG_DWORD : `IRP_OFS_CFG_WORD);
  assign sw_reset = host_rd && host_addr == `IRP_OFS_RESET;
  assign status_wr = host_wr && data_hit && register_index_pointer_q == `IRP_IDX_STATUS;
  assign stop_pulse = status_wr && host_wdata[`IRP_BIT_STOP] && !stop_q;

  // Babble: count bytes of the current frame, saturating at the limit
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_count_q <= 11'h000;
    else if (!tx_active)
      tx_count_q <= 11'h000;
    else if (tx_byte && tx_count_q != `IRP_BABBLE_BYTES)
      tx_count_q <= tx_count_q + 11'h001;
  end
  assign babble_set = tx_active && tx_byte && tx_count_q == `IRP_BABBLE_BYTES - 11'h001;

  // Heartbeat window after each transmission
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sqe_q <= irp_pkg::IRP_SQE_IDLE;
      sqe_count_q <= 6'h00;
    end
    else
    begin
      case (sqe_q)
        irp_pkg::IRP_SQE_IDLE:
        begin
          sqe_count_q <= 6'h00;
          if (tx_end)
            sqe_q <= irp_pkg::IRP_SQE_WAIT;
        end
        irp_pkg::IRP_SQE_WAIT:
        begin
          sqe_count_q <= sqe_count_q + 6'h01;
          if (collision_in || sqe_count_q == 6'(SQE_CYCLES - 1))
            sqe_q <= irp_pkg::IRP_SQE_DONE;
        end
        irp_pkg::IRP_SQE_DONE:
          sqe_q <= irp_pkg::IRP_SQE_IDLE;
        default:
          sqe_q <= irp_pkg::IRP_SQE_IDLE;
      endcase
    end
  end
  assign sqe_fail = sqe_q == irp_pkg::IRP_SQE_WAIT && !collision_in
    && sqe_count_q == 6'(SQE_CYCLES - 1);
  assign coll_set = sqe_fail || (twisted_pair_mode && link_fail && tx_attempt);

  // Bus grant timeout counter; restarts on each new hold request
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      bus_wait_count_q <= 16'h0000;
    else if (!hold_req || bus_grant_acknowledge)
      bus_wait_count_q <= 16'h0000;
    else if (bus_wait_count_q != 16'(BUS_TIMEOUT_CYCLES))
      bus_wait_count_q <= bus_wait_count_q + 16'h0001;
  end

  // Pointer survives stop
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      register_index_pointer_q <= 8'h00;
    else if (sw_reset)
      register_index_pointer_q <= 8'h00;
    else if (host_wr && ptr_hit)
      register_index_pointer_q <= host_wdata[7:0];
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      babble_flag_q <= 1'b0;
      collision_heartbeat_flag_q <= 1'b0;
      missed_frame_flag_q <= 1'b0;
      bus_grant_timeout_flag_q <= 1'b0;
      init_done_flag_q <= 1'b0;
    end
    else if (sw_reset || stop_pulse)
    begin
      babble_flag_q <= 1'b0;
      collision_heartbeat_flag_q <= 1'b0;
      missed_frame_flag_q <= 1'b0;
      bus_grant_timeout_flag_q <= 1'b0;
      init_done_flag_q <= 1'b0;
    end
    else
    begin
      // Set beats clear so no event is dropped
      babble_flag_q <= w1c(babble_flag_q, babble_set, status_wr && host_wdata[`IRP_BIT_BABBLE]);
      collision_heartbeat_flag_q <= w1c(collision_heartbeat_flag_q, coll_set,
        status_wr && host_wdata[`IRP_BIT_COLL]);
      missed_frame_flag_q <= w1c(missed_frame_flag_q, frame_missed,
        status_wr && host_wdata[`IRP_BIT_MISS]);
      bus_grant_timeout_flag_q <= w1c(bus_grant_timeout_flag_q,
        hold_req && !bus_grant_acknowledge && bus_wait_count_q == 16'(BUS_TIMEOUT_CYCLES - 1),
        status_wr && host_wdata[`IRP_BIT_BUS_TIMEOUT]);
      init_done_flag_q <= w1c(init_done_flag_q, init_read_done,
        status_wr && host_wdata[`IRP_BIT_INIT_DONE]);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interrupt_gate_q <= 1'b0;
      stop_q <= 1'b1;
    end
    else if (sw_reset)
    begin
      interrupt_gate_q <= 1'b0;
      stop_q <= 1'b1;
    end
    else if (status_wr)
    begin
      // Stop clears the gate even if the same write sets it
      interrupt_gate_q <= host_wdata[`IRP_BIT_GATE] && !stop_pulse;
      stop_q <= host_wdata[`IRP_BIT_STOP];
    end
  end

  // Mask register at index 3; masks only, cleared by resets and stop
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      interrupt_mask_register_q <= 16'h0000;
    else if (sw_reset || stop_pulse)
      interrupt_mask_register_q <= 16'h0000;
    else if (host_wr && data_hit && register_index_pointer_q == `IRP_IDX_MASK)
      interrupt_mask_register_q <= host_wdata[15:0];
  end

  assign error_summary = babble_flag_q | collision_heartbeat_flag_q
    | missed_frame_flag_q | bus_grant_timeout_flag_q;
  // Collision flag deliberately absent here
  assign interrupt_summary = (babble_flag_q & ~interrupt_mask_register_q[`IRP_BIT_BABBLE])
    | (missed_frame_flag_q & ~interrupt_mask_register_q[`IRP_BIT_MISS])
    | (bus_grant_timeout_flag_q & ~interrupt_mask_register_q[`IRP_BIT_BUS_TIMEOUT])
    | (init_done_flag_q & ~interrupt_mask_register_q[`IRP_BIT_INIT_DONE])
    | (|other_pending);

  always_comb
  begin
    status_word = 16'h0000;
    status_word[`IRP_BIT_ERR] = error_summary;
    status_word[`IRP_BIT_BABBLE] = babble_flag_q;
    status_word[`IRP_BIT_COLL] = collision_heartbeat_flag_q;
    status_word[`IRP_BIT_MISS] = missed_frame_flag_q;
    status_word[`IRP_BIT_BUS_TIMEOUT] = bus_grant_timeout_flag_q;
    status_word[`IRP_BIT_INIT_DONE] = init_done_flag_q;
    status_word[`IRP_BIT_SUMMARY] = interrupt_summary;
    status_word[`IRP_BIT_GATE] = interrupt_gate_q;
    status_word[`IRP_BIT_STOP] = stop_q;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= interrupt_gate_q && interrupt_summary;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      host_rdata <= 32'h0000_0000;
    else if (host_rd && ptr_hit && !sw_reset)
      host_rdata <= {24'h000000, register_index_pointer_q};
    else if (host_rd && data_hit)
      case (register_index_pointer_q)
        `IRP_IDX_STATUS: host_rdata <= {16'h0000, status_word};
        `IRP_IDX_MASK: host_rdata <= {16'h0000, interrupt_mask_register_q};
        default: host_rdata <= 32'h0000_0000;
      endcase
    else if (host_rd && cfg_hit)
      host_rdata <= {16'h0000, cfg_rdata};
    else
      host_rdata <= 32'h0000_0000;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_index <= 8'h00;
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      cfg_wdata <= 16'h0000;
      stop_state <= 1'b1;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      cfg_index <= register_index_pointer_q;
      cfg_rd <= host_rd && cfg_hit;
      cfg_wr <= host_wr && cfg_hit;
      cfg_wdata <= host_wdata[15:0];
      stop_state <= sw_reset || (status_wr ? host_wdata[`IRP_BIT_STOP] : stop_q);
      soft_reset_pulse <= sw_reset;
    end
  end

  babble_irq_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    babble_flag_q && interrupt_gate_q && !interrupt_mask_register_q[`IRP_BIT_BABBLE] |=> irq)
    else $error("babble did not raise irq");
  coll_noirq_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    collision_heartbeat_flag_q && !babble_flag_q && !missed_frame_flag_q && !bus_grant_timeout_flag_q
    && !init_done_flag_q && other_pending == 6'h00 |-> !interrupt_summary && error_summary)
    else $error("collision flag interrupted");
  err_or_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    error_summary == (babble_flag_q || collision_heartbeat_flag_q || missed_frame_flag_q
    || bus_grant_timeout_flag_q))
    else $error("error summary wrong");
  set_wins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    frame_missed && !sw_reset && !stop_pulse |=> missed_frame_flag_q)
    else $error("missed event lost");
  stop_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stop_pulse |=> !babble_flag_q && !init_done_flag_q && !interrupt_gate_q)
    else $error("stop did not clear");
  ptr_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stop_pulse && !(host_wr && ptr_hit) |=> $stable(register_index_pointer_q))
    else $error("pointer changed on stop");
  sreset_ptr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sw_reset |=> register_index_pointer_q == 8'h00 && soft_reset_pulse)
    else $error("soft reset missed");
  gate_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !interrupt_gate_q |=> !irq)
    else $error("irq while gate off");

  // Window opens on tx_end seen while idle; a quiet window must end with the flag one edge later
  sequence sqe_open_s;
    tx_end && sqe_q == irp_pkg::IRP_SQE_IDLE;
  endsequence
  sequence sqe_answer_s;
    collision_in || collision_heartbeat_flag_q || sw_reset || stop_pulse;
  endsequence
  sqe_fail_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sqe_open_s |-> ##[1:SQE_LATE] sqe_answer_s)
    else $error("heartbeat miss not flagged");
  sreset_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sw_reset |=> !babble_flag_q && !bus_grant_timeout_flag_q && !interrupt_gate_q && stop_q)
    else $error("soft reset did not clear");
  zero_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    status_wr && !host_wdata[`IRP_BIT_BABBLE] && babble_flag_q && !stop_pulse && !sw_reset |=> babble_flag_q)
    else $error("babble lost on zero write");
  gate_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    status_wr && !stop_pulse && !sw_reset |=> interrupt_gate_q == $past(host_wdata[`IRP_BIT_GATE]))
    else $error("gate not written");
endmodule

// ==== irp_regs_tb.sv ====
/*
  Self-checking bench for the indexed register port and status word.
  Assumes irp_regs with a shortened bus timeout and a 20 MHz core clock.
*/
`timescale 1ns/1ps

module irp_regs_tb;
  localparam int BUS_TO_CYC = 16;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic dword_mode = 1'b0;
  logic [4:0] host_addr = 5'h00;
  logic host_rd = 1'b0;
  logic host_wr = 1'b0;
  logic [31:0] host_wdata = 32'h0;
  logic [31:0] host_rdata;
  logic [7:0] cfg_index;
  logic cfg_rd;
  logic cfg_wr;
  logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic tx_active = 1'b0;
  logic tx_byte = 1'b0;
  logic tx_attempt = 1'b0;
  logic tx_end = 1'b0;
  logic collision_in = 1'b0;
  logic twisted_pair_mode = 1'b0;
  logic link_fail = 1'b0;
  logic frame_missed = 1'b0;
  logic hold_req = 1'b0;
  logic bus_grant_acknowledge = 1'b0;
  logic init_read_done = 1'b0;
  logic stop_state;
  logic soft_reset_pulse;
  logic irq;
  logic sr_seen = 1'b0;
  logic cfg_wr_seen = 1'b0;
  logic cfg_rd_seen = 1'b0;
  logic [5:0] other_pending = 6'h00;
  logic [31:0] v;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  // Config space answers with a value tied to the index so a wrong index shows
  assign cfg_rdata = {8'hA5, cfg_index};

  irp_regs #(.BUS_TIMEOUT_CYCLES(BUS_TO_CYC)) dut (.core_clk(core_clk), .reset_n(reset_n), .dword_mode(dword_mode),
    .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .cfg_index(cfg_index), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .tx_active(tx_active), .tx_byte(tx_byte), .tx_attempt(tx_attempt), .tx_end(tx_end),
    .collision_in(collision_in), .twisted_pair_mode(twisted_pair_mode), .link_fail(link_fail),
    .frame_missed(frame_missed), .hold_req(hold_req), .bus_grant_acknowledge(bus_grant_acknowledge),
    .init_read_done(init_read_done), .other_pending(other_pending), .stop_state(stop_state),
    .soft_reset_pulse(soft_reset_pulse), .irq(irq));

  always #25 core_clk = ~core_clk;

  // Sticky monitors: pulse timing is fixed by the design, the bench only needs to see them
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (soft_reset_pulse === 1'b1) sr_seen <= 1'b1;
    if (cfg_wr === 1'b1) cfg_wr_seen <= 1'b1;
    if (cfg_rd === 1'b1) cfg_rd_seen <= 1'b1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Each bus task starts just after an edge and leaves one idle edge behind it
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    cyc(1);
    host_wr = 1'b0;
    init_read_done = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    host_addr = a;
    host_rd = 1'b1;
    cyc(1);
    host_rd = 1'b0;
    d = host_rdata;
    cyc(1);
  endtask

  // Status bits that this block owns, less stop bit 2: 15..11, 8, 7, 6
  task automatic st(input logic [31:0] exp);
    rd(5'h10, v);
    chk(v & 32'h0000F9C0, exp);
  endtask

  task automatic t_ptr();
    rd(5'h12, v);
    chk(v, 32'h0);
    wr(5'h12, 32'hFFFF_FF05);
    rd(5'h12, v);
    chk(v, 32'h05);
    chk({24'h0, cfg_index}, 32'h05);
    rd(5'h16, v);
    chk(v, 32'h0000A505);
    chk({31'h0, cfg_rd_seen}, 32'h1);
    wr(5'h16, 32'h0000_1234);
    chk({16'h0, cfg_wdata}, 32'h1234);
    chk({31'h0, cfg_wr_seen}, 32'h1);
    dword_mode = 1'b1;
    wr(5'h14, 32'h03);
    rd(5'h1C, v);
    chk(v, 32'h0000A503);
    wr(5'h10, 32'h0);
    rd(5'h10, v);
    chk(v & 32'h5900, 32'h0);
    dword_mode = 1'b0;
    wr(5'h12, 32'h0);
    // Stop stays set so the babble test can show that rewriting it is a no-op
    wr(5'h10, 32'h0044);
  endtask

  task automatic t_babble();
    tx_active = 1'b1;
    tx_byte = 1'b1;
    cyc(1518);
    tx_byte = 1'b0;
    st(32'h0040);
    tx_byte = 1'b1;
    cyc(1);
    tx_byte = 1'b0;
    tx_active = 1'b0;
    cyc(3);
    st(32'hC0C0);
    chk({31'h0, irq}, 32'h1);
    wr(5'h10, 32'h0044);
    st(32'hC0C0);
    wr(5'h10, 32'h4040);
    st(32'h0040);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_coll();
    tx_end = 1'b1;
    cyc(1);
    tx_end = 1'b0;
    cyc(30);
    st(32'h0040);
    cyc(15);
    st(32'hA040);
    chk({31'h0, irq}, 32'h0);
    wr(5'h10, 32'h2040);
    twisted_pair_mode = 1'b1;
    link_fail = 1'b1;
    tx_attempt = 1'b1;
    cyc(1);
    tx_attempt = 1'b0;
    cyc(2);
    st(32'hA040);
    wr(5'h10, 32'h2040);
    twisted_pair_mode = 1'b0;
    link_fail = 1'b0;
  endtask

  task automatic t_miss();
    wr(5'h12, 32'h03);
    wr(5'h10, 32'h1000);
    wr(5'h12, 32'h00);
    frame_missed = 1'b1;
    cyc(1);
    frame_missed = 1'b0;
    cyc(3);
    st(32'h9040);
    chk({31'h0, irq}, 32'h0);
    wr(5'h12, 32'h03);
    wr(5'h10, 32'h0);
    wr(5'h12, 32'h00);
    st(32'h90C0);
    chk({31'h0, irq}, 32'h1);
    wr(5'h10, 32'h1000);
    st(32'h0000);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_bus_timeout();
    hold_req = 1'b1;
    cyc(BUS_TO_CYC - 4);
    st(32'h0000);
    cyc(8);
    hold_req = 1'b0;
    st(32'h8880);
    chk({31'h0, irq}, 32'h0);
    wr(5'h10, 32'h0840);
    other_pending = 6'h01;
    st(32'h00C0);
    chk({31'h0, irq}, 32'h1);
    other_pending = 6'h00;
  endtask

  task automatic t_init_done();
    init_read_done = 1'b1;
    cyc(1);
    init_read_done = 1'b0;
    cyc(3);
    st(32'h01C0);
    chk({31'h0, irq}, 32'h1);
    // Event lands in the same cycle as the clear; wr drops it again
    init_read_done = 1'b1;
    wr(5'h10, 32'h0140);
    st(32'h01C0);
    chk({31'h0, stop_state}, 32'h0);
    wr(5'h10, 32'h0044);
    st(32'h0000);
    chk({31'h0, stop_state}, 32'h1);
  endtask

  task automatic t_soft();
    hold_req = 1'b1;
    cyc(BUS_TO_CYC + 4);
    hold_req = 1'b0;
    wr(5'h12, 32'h05);
    rd(5'h14, v);
    cyc(3);
    chk({31'h0, sr_seen}, 32'h1);
    rd(5'h12, v);
    chk(v, 32'h0);
    st(32'h0000);
  endtask

  initial
  begin
    cyc(10);
    reset_n = 1'b1;
    cyc(2);
    t_ptr();
    t_babble();
    t_coll();
    t_miss();
    t_bus_timeout();
    t_init_done();
    t_soft();
    summarize();
  end
endmodule
